/* inc/chp_pkg.sv */
package chp_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int POR_RELEASE_NS = 5000;
  // longest time: round down, never below one cycle
  localparam int POR_CYCLES_RAW = POR_RELEASE_NS / CLK_PERIOD_NS;
  localparam int POR_CYCLES = (POR_CYCLES_RAW < 1) ? 1 : POR_CYCLES_RAW;
  localparam int INIT_CYCLES = 8;
  localparam int ERR_HOLD_CYCLES = 16;
  localparam int AS_CLK_DIV = 4;
  localparam int CNT_W = 8;
  localparam int SYNC_W = 7;
  // scheme-select codes
  localparam logic [1:0] SCHEME_AS = 2'h0;
  localparam logic [1:0] SCHEME_PS = 2'h1;
  // bit positions inside the synchroniser word
  localparam int SY_RCFG = 0;
  localparam int SY_STAT = 1;
  localparam int SY_FIN = 2;
  localparam int SY_SCLK = 3;
  localparam int SY_CS = 4;
  localparam int SY_SEL_LO = 5;
  localparam int SY_SEL_HI = 6;

  typedef enum logic [2:0] {
    ST_POR,
    ST_WAIT,
    ST_CONFIG,
    ST_RELEASE,
    ST_INIT,
    ST_USER,
    ST_RESET,
    ST_ERROR
  } chp_state_e;
endpackage : chp_pkg

/* src/chp_sync.sv */
module chp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
  } chp_sync_s;

  chp_sync_s s_r;
  chp_sync_s s_nxt;

  // two flip-flops, only ff2 is read
  always_comb begin
    s_nxt.ff1 = d;
    s_nxt.ff2 = s_r.ff1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.ff2;
endmodule : chp_sync

/* src/chp_div.sv */
module chp_div #(
  parameter int DIV = 4,
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  output logic tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } chp_div_s;

  chp_div_s s_r;
  chp_div_s s_nxt;

  // one-cycle enable every DIV cycles while en
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!en) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt == W'(DIV - 1)) begin
      s_nxt.cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule : chp_div

/* src/chp_cfg_ctrl.sv */
// What this block does
// - two-bit scheme select picks active or passive serial and routes the clock pin
// - reconfig request low in user mode: drop configuration, reset, float user pins
// - reconfig request back high starts a fresh configuration cycle
// - after power-up pull status low, release within 5 us
// - configuration error: device pulls status low
// - status driven low externally during configuration or init: error state
// - after init the status line is ignored entirely
// - done line held low before and during configuration
// - release done only after error-free data, before init begins
// - sense done line high before initialising and entering user mode
// - done line pulled low after init has no effect
// - passive serial: data bit captured on rising serial clock edge
module chp_cfg_ctrl
  import chp_pkg::*;
#(
  parameter int INIT_CYC = chp_pkg::INIT_CYCLES,
  parameter int ERR_HOLD = chp_pkg::ERR_HOLD_CYCLES,
  parameter int CLK_DIV = chp_pkg::AS_CLK_DIV
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic SCHEME_SELECT_HI,
  input wire logic SCHEME_SELECT_LO,
  input wire logic RECONFIG_REQUEST_N,
  input wire logic CHIP_SELECT_IN_N,
  input wire logic CFG_STATUS_N_IN,
  output logic CFG_STATUS_N_OUT,
  output logic CFG_STATUS_N_OE,
  input wire logic CFG_FINISHED_IN,
  output logic CFG_FINISHED_OUT,
  output logic CFG_FINISHED_OE,
  input wire logic CFG_SERIAL_CLOCK_IN,
  output logic CFG_SERIAL_CLOCK_OUT,
  output logic CFG_SERIAL_CLOCK_OE,
  input wire logic DATA_COMPLETE,
  input wire logic DATA_ERROR,
  output logic [1:0] ACTIVE_SCHEME,
  output logic BIT_STROBE,
  output logic USER_IO_HIZ,
  output logic USER_MODE
);
  import chp_pkg::*;

  typedef struct packed {
    chp_state_e state;
    logic [CNT_W-1:0] cnt;
    logic [1:0] scheme;
    logic clk_prev;
    logic status_oe;
    logic done_oe;
    logic cfg_serial_clock_out;
    logic cfg_serial_clock_oe;
    logic bit_strobe;
    logic io_hiz;
    logic user_mode;
  } chp_main_s;

  localparam chp_main_s RST_VAL = '{
    state: ST_POR,
    cnt: '0,
    scheme: SCHEME_AS,
    clk_prev: 1'b0,
    status_oe: 1'b1,
    done_oe: 1'b1,
    cfg_serial_clock_out: 1'b0,
    cfg_serial_clock_oe: 1'b0,
    bit_strobe: 1'b0,
    io_hiz: 1'b1,
    user_mode: 1'b0
  };

  chp_main_s s_r;
  chp_main_s s_nxt;
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_s;
  logic as_tick;
  logic rcfg_s;
  logic stat_s;
  logic fin_s;
  logic sclk_s;
  logic cs_n_s;
  logic [1:0] sel_s;

  assign pin_raw = {SCHEME_SELECT_HI, SCHEME_SELECT_LO, CHIP_SELECT_IN_N,
                    CFG_SERIAL_CLOCK_IN, CFG_FINISHED_IN, CFG_STATUS_N_IN,
                    RECONFIG_REQUEST_N};

  chp_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .d(pin_raw),
    .q(pin_s)
  );

  assign rcfg_s = pin_s[SY_RCFG];
  assign stat_s = pin_s[SY_STAT];
  assign fin_s = pin_s[SY_FIN];
  assign sclk_s = pin_s[SY_SCLK];
  assign cs_n_s = pin_s[SY_CS];
  assign sel_s = {pin_s[SY_SEL_HI], pin_s[SY_SEL_LO]};

  // active serial clock rate
  chp_div #(
    .DIV(CLK_DIV),
    .W(CNT_W)
  ) u_div (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .en(s_r.cfg_serial_clock_oe),
    .tick(as_tick)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.bit_strobe = 1'b0;
    s_nxt.clk_prev = sclk_s;
    case (s_r.state)
      ST_POR: begin
        if (s_r.cnt == CNT_W'(POR_CYCLES - 1)) begin
          s_nxt.state = ST_WAIT;
          s_nxt.cnt = '0;
        end else begin
          s_nxt.cnt = s_r.cnt + CNT_W'(1);
        end
      end
      ST_WAIT: begin
        // waits however long the far side holds status low
        if (stat_s && !cs_n_s) begin
          s_nxt.scheme = sel_s;
          s_nxt.cnt = '0;
          s_nxt.cfg_serial_clock_out = 1'b0;
          if (sel_s == SCHEME_AS || sel_s == SCHEME_PS) begin
            s_nxt.state = ST_CONFIG;
          end else begin
            s_nxt.state = ST_ERROR;
          end
        end
      end
      ST_CONFIG: begin
        if (s_r.scheme == SCHEME_PS) begin
          s_nxt.bit_strobe = sclk_s && !s_r.clk_prev;
        end else if (as_tick) begin
          s_nxt.cfg_serial_clock_out = !s_r.cfg_serial_clock_out;
          s_nxt.bit_strobe = !s_r.cfg_serial_clock_out;
        end
        if (DATA_ERROR) begin
          s_nxt.state = ST_ERROR;
          s_nxt.cnt = '0;
        end else if (!stat_s) begin
          s_nxt.state = ST_ERROR;
          s_nxt.cnt = '0;
        end else if (DATA_COMPLETE) begin
          s_nxt.state = ST_RELEASE;
          s_nxt.cfg_serial_clock_out = 1'b0;
        end
      end
      ST_RELEASE: begin
        if (!stat_s) begin
          s_nxt.state = ST_ERROR;
          s_nxt.cnt = '0;
        end else if (fin_s) begin
          s_nxt.state = ST_INIT;
          s_nxt.cnt = '0;
        end
      end
      ST_INIT: begin
        if (!stat_s) begin
          s_nxt.state = ST_ERROR;
          s_nxt.cnt = '0;
        end else if (s_r.cnt == CNT_W'(INIT_CYC - 1)) begin
          s_nxt.state = ST_USER;
        end else begin
          s_nxt.cnt = s_r.cnt + CNT_W'(1);
        end
      end
      ST_USER: begin
        s_nxt.state = ST_USER;
      end
      ST_RESET: begin
        if (rcfg_s) begin
          s_nxt.state = ST_POR;
          s_nxt.cnt = '0;
        end
      end
      ST_ERROR: begin
        if (s_r.cnt == CNT_W'(ERR_HOLD - 1)) begin
          s_nxt.state = ST_WAIT;
          s_nxt.cnt = '0;
        end else begin
          s_nxt.cnt = s_r.cnt + CNT_W'(1);
        end
      end
      default: begin
        s_nxt.state = ST_POR;
        s_nxt.cnt = '0;
      end
    endcase
    if (!rcfg_s && s_r.state != ST_POR) begin
      s_nxt.state = ST_RESET;
      s_nxt.cnt = '0;
      s_nxt.cfg_serial_clock_out = 1'b0;
    end
    // clock pin idles low whenever it is not driven
    if (s_nxt.state != ST_CONFIG) begin
      s_nxt.cfg_serial_clock_out = 1'b0;
    end
    s_nxt.status_oe = (s_nxt.state == ST_POR) || (s_nxt.state == ST_ERROR) ||
                      (s_nxt.state == ST_RESET);
    s_nxt.done_oe = !((s_nxt.state == ST_RELEASE) || (s_nxt.state == ST_INIT) ||
                      (s_nxt.state == ST_USER));
    s_nxt.cfg_serial_clock_oe = (s_nxt.state == ST_CONFIG) && (s_nxt.scheme == SCHEME_AS);
    s_nxt.io_hiz = (s_nxt.state != ST_USER);
    s_nxt.user_mode = (s_nxt.state == ST_USER);
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      s_r <= RST_VAL;
    end else begin
      s_r <= s_nxt;
    end
  end

  // open-drain pins only ever pull low
  assign CFG_STATUS_N_OUT = 1'b0;
  assign CFG_FINISHED_OUT = 1'b0;
  assign CFG_STATUS_N_OE = s_r.status_oe;
  assign CFG_FINISHED_OE = s_r.done_oe;
  assign CFG_SERIAL_CLOCK_OUT = s_r.cfg_serial_clock_out;
  assign CFG_SERIAL_CLOCK_OE = s_r.cfg_serial_clock_oe;
  assign ACTIVE_SCHEME = s_r.scheme;
  assign BIT_STROBE = s_r.bit_strobe;
  assign USER_IO_HIZ = s_r.io_hiz;
  assign USER_MODE = s_r.user_mode;

  localparam int POR_BOUND = 130;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  sequence cfg_ok_s;
    s_r.state == ST_CONFIG && rcfg_s && stat_s && !DATA_ERROR;
  endsequence

  sequence data_done_s;
    cfg_ok_s ##0 DATA_COMPLETE;
  endsequence

  por_release_a: assert property ($fell(SYS_RST) |-> ##[1:POR_BOUND] !CFG_STATUS_N_OE)
    else $error("status not released after power-up");
  cfg_error_a: assert property (s_r.state == ST_CONFIG && rcfg_s && DATA_ERROR
      |=> CFG_STATUS_N_OE && s_r.state == ST_ERROR)
    else $error("config error not reported on status");
  ext_error_a: assert property (s_r.state == ST_CONFIG && rcfg_s && !stat_s
      |=> s_r.state == ST_ERROR)
    else $error("external status low not taken as error");
  user_hold_a: assert property (s_r.state == ST_USER && rcfg_s
      |=> USER_MODE && !CFG_STATUS_N_OE && !CFG_FINISHED_OE)
    else $error("user mode disturbed by status or done");
  reconfig_rst_a: assert property (!rcfg_s && s_r.state == ST_USER
      |=> USER_IO_HIZ && !USER_MODE && s_r.state == ST_RESET)
    else $error("reconfig request did not reset device");
  reconfig_go_a: assert property (s_r.state == ST_RESET && rcfg_s
      |=> s_r.state == ST_POR ##1 CFG_STATUS_N_OE)
    else $error("no new cycle after reconfig request released");
  done_low_a: assert property (s_r.state inside {ST_POR, ST_WAIT, ST_CONFIG, ST_ERROR}
      |-> CFG_FINISHED_OE)
    else $error("done line released too early");
  done_release_a: assert property (data_done_s |=> !CFG_FINISHED_OE)
    else $error("done line not released after data");
  init_gate_a: assert property (s_r.state == ST_RELEASE && !fin_s
      |=> s_r.state != ST_INIT && !USER_MODE)
    else $error("init started without done line high");
  ps_capture_a: assert property (cfg_ok_s ##0 (s_r.scheme == SCHEME_PS && sclk_s
      && !s_r.clk_prev) |=> BIT_STROBE)
    else $error("passive serial edge not captured");
  scheme_route_a: assert property (s_r.state == ST_CONFIG
      |-> CFG_SERIAL_CLOCK_OE == (s_r.scheme == SCHEME_AS))
    else $error("serial clock routed against scheme");
  por_hold_a: assert property (s_r.state == ST_POR
      |-> CFG_STATUS_N_OE)
    else $error("status not held low during power-up");
  strobe_pulse_a: assert property (BIT_STROBE |=> !BIT_STROBE)
    else $error("bit strobe longer than one cycle");
  hiz_user_a: assert property (USER_IO_HIZ == !USER_MODE)
    else $error("user pins driven outside user mode");
  idle_clk_a: assert property (!CFG_SERIAL_CLOCK_OE
      |-> !CFG_SERIAL_CLOCK_OUT)
    else $error("serial clock left high while not driven");
  err_status_a: assert property (s_r.state == ST_ERROR
      |-> CFG_STATUS_N_OE)
    else $error("status released during error hold");
  reset_pins_a: assert property (s_r.state == ST_RESET
      |-> USER_IO_HIZ && CFG_STATUS_N_OE && CFG_FINISHED_OE)
    else $error("reset state not holding pins");
  wait_gate_a: assert property (s_r.state == ST_WAIT && !stat_s
      |=> s_r.state inside {ST_WAIT, ST_RESET})
    else $error("configuration started while status held low");
endmodule : chp_cfg_ctrl

/* dv/chp_far_model.sv */
module chp_far_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic dev_status_oe,
  input wire logic dev_fin_oe,
  input wire logic [15:0] hold_cyc,
  input wire logic pull_status,
  input wire logic pull_done,
  input wire logic [7:0] pulse_n,
  input wire logic pulse_go,
  output logic status_net,
  output logic done_net,
  output logic sclk,
  output logic cs_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold;
  // chip select kept low the whole run
  assign cs_n = 1'b0;
  // wired-AND nets with pull-ups: released reads high
  assign status_net = !(dev_status_oe || pull_status || hold > 0);
  assign done_net = !(dev_fin_oe || pull_done);
  // memory keeps status low a while after power-up
  always @(posedge clk) begin
    if (rst) begin
      hold <= int'(hold_cyc);
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
  end
  // passive clock: 3 cycles high, 3 low, still between bursts
  initial sclk = 1'b0;
  always @(posedge pulse_go) begin
    repeat (pulse_n) begin
      repeat (3) @(posedge clk);
      #1 sclk = 1'b1;
      repeat (3) @(posedge clk);
      #1 sclk = 1'b0;
    end
  end
endmodule : chp_far_model

/* dv/chp_cfg_ctrl_bench.sv */
module chp_cfg_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import chp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel_hi = 1'b0;
  logic sel_lo = 1'b0;
  logic rcfg_n = 1'b1;
  logic dcomp = 1'b0;
  logic derr = 1'b0;
  logic pull_s = 1'b0;
  logic pull_d = 1'b0;
  logic pgo = 1'b0;
  logic [7:0] pn = 8'h01;
  logic [15:0] hold = 16'h0000;
  wire status_net, done_net, sclk, cs_n;
  logic s_out, s_oe, f_out, f_oe, c_out, c_oe, strobe, hiz, umode;
  logic [1:0] sch;
  int n_errors = 0;
  int tests_run = 0;
  int n_strobe = 0;
  int n_crise = 0;
  int base_s;
  int base_c;
  logic c_last = 1'b0;
  int i;
  integer seed;

  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (strobe === 1'b1) n_strobe = n_strobe + 1;
    if (c_out === 1'b1 && c_last === 1'b0) n_crise = n_crise + 1;
    c_last = c_out;
  end

  chp_cfg_ctrl dut (.REF_CLK(clk), .SYS_RST(rst), .SCHEME_SELECT_HI(sel_hi),
    .SCHEME_SELECT_LO(sel_lo), .RECONFIG_REQUEST_N(rcfg_n), .CHIP_SELECT_IN_N(cs_n),
    .CFG_STATUS_N_IN(status_net), .CFG_STATUS_N_OUT(s_out), .CFG_STATUS_N_OE(s_oe),
    .CFG_FINISHED_IN(done_net), .CFG_FINISHED_OUT(f_out), .CFG_FINISHED_OE(f_oe),
    .CFG_SERIAL_CLOCK_IN(sclk), .CFG_SERIAL_CLOCK_OUT(c_out), .CFG_SERIAL_CLOCK_OE(c_oe),
    .DATA_COMPLETE(dcomp), .DATA_ERROR(derr), .ACTIVE_SCHEME(sch), .BIT_STROBE(strobe),
    .USER_IO_HIZ(hiz), .USER_MODE(umode));

  chp_far_model far (.clk(clk), .rst(rst), .dev_status_oe(s_oe), .dev_fin_oe(f_oe),
    .hold_cyc(hold), .pull_status(pull_s), .pull_done(pull_d), .pulse_n(pn),
    .pulse_go(pgo), .status_net(status_net), .done_net(done_net), .sclk(sclk), .cs_n(cs_n));

  task automatic tally_and_finish;
    $display("checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  function automatic logic pick(input int w);
    case (w)
      0: return s_oe;
      1: return f_oe;
      2: return c_oe;
      default: return umode;
    endcase
  endfunction : pick

  // bounded wait; returns cycles spent
  task automatic wait_on(input int w, input logic v, output int n);
    for (n = 0; n < 2000 && pick(w) !== v; n++) tick(1);
    if (pick(w) !== v) begin
      chk("wait_bound", 16'h0000, 16'h0001);
      tally_and_finish();
    end
  endtask : wait_on

  task automatic to_user;
    int n;
    dcomp = 1'b1;
    wait_on(1, 1'b0, n);
    pull_d = 1'b1;
    tick(20);
    chk("held_done_user", 16'(umode), 16'h0000);
    pull_d = 1'b0;
    wait_on(3, 1'b1, n);
    chk("init_wait", 16'(n >= INIT_CYCLES), 16'h0001);
    chk("io_hiz", 16'(hiz), 16'h0000);
    dcomp = 1'b0;
  endtask : to_user

  task automatic reconfig(input logic [1:0] sc);
    int n;
    {sel_hi, sel_lo} = sc;
    tick(1);
    rcfg_n = 1'b0;
    tick(6);
    chk("rst_hiz", 16'(hiz), 16'h0001);
    chk("rst_user", 16'(umode), 16'h0000);
    chk("rst_done_oe", 16'(f_oe), 16'h0001);
    rcfg_n = 1'b1;
    wait_on(0, 1'b0, n);
    chk("repor_len", 16'(n <= POR_CYCLES + 8), 16'h0001);
  endtask : reconfig

  initial begin
    seed = 32'h8935;
    hold = 16'(130 + ($unsigned($random(seed)) % 200));
    tick(8);
    chk("por_status_oe", 16'(s_oe), 16'h0001);
    chk("por_done_oe", 16'(f_oe), 16'h0001);
    chk("od_data", 16'({s_out, f_out}), 16'h0000);
    rst = 1'b0;
    wait_on(0, 1'b0, i);
    chk("por_len", 16'(i <= POR_CYCLES + 4), 16'h0001);
    wait_on(2, 1'b1, i);
    chk("far_hold", 16'(i + POR_CYCLES >= int'(hold)), 16'h0001);
    chk("scheme_as", 16'(sch), 16'(SCHEME_AS));
    base_s = n_strobe;
    base_c = n_crise;
    tick(40);
    chk("as_strobes", 16'(n_strobe - base_s >= 4 && n_strobe - base_s <= 6), 16'h0001);
    chk("as_clk_rises", 16'(n_crise - base_c), 16'(n_strobe - base_s));
    to_user();
    pull_s = 1'b1;
    pull_d = 1'b1;
    tick(30);
    chk("user_kept", 16'(umode), 16'h0001);
    chk("no_retry", 16'(s_oe), 16'h0000);
    pull_s = 1'b0;
    pull_d = 1'b0;
    reconfig(SCHEME_PS);
    tick(10);
    chk("ps_no_drive", 16'(c_oe), 16'h0000);
    chk("scheme_ps", 16'(sch), 16'(SCHEME_PS));
    chk("ps_clk_idle", 16'(c_out), 16'h0000);
    base_s = n_strobe;
    base_c = n_crise;
    pn = 8'(1 + ($unsigned($random(seed)) % 16));
    pgo = 1'b1;
    tick(int'(pn) * 6 + 10);
    pgo = 1'b0;
    chk("ps_strobes", 16'(n_strobe - base_s), 16'(pn));
    chk("ps_no_clk", 16'(n_crise - base_c), 16'h0000);
    derr = 1'b1;
    tick(2);
    chk("err_status", 16'(s_oe), 16'h0001);
    derr = 1'b0;
    wait_on(0, 1'b0, i);
    tick(10);
    pull_s = 1'b1;
    tick(6);
    pull_s = 1'b0;
    chk("ext_err", 16'(s_oe), 16'h0001);
    wait_on(0, 1'b0, i);
    tick(10);
    to_user();
    reconfig(2'h2);
    tick(10);
    chk("bad_scheme", 16'(s_oe), 16'h0001);
    tally_and_finish();
  end
endmodule : chp_cfg_ctrl_bench
